// >>> common/lmhcd_pkg.sv
package lmhcd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int CLK_PERIOD_NS = 20;
  localparam int ROW_TIME_NS = 2000;
  localparam int ROW_CYCLES = (ROW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEC_TIME_NS = 1000000000;
  localparam int SEC_CYCLES_DEF = SEC_TIME_NS / CLK_PERIOD_NS;
  localparam int SF_LEN = 12;
  localparam int ROWS = 8;
  localparam int RD_BITS = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame lengths and command fields.
  localparam logic [4:0] LEN_DSP = 5'h08;
  localparam logic [4:0] LEN_CFG = 5'h10;
  localparam logic [4:0] LEN_DIR = 5'h18;
  localparam logic [4:0] LEN_MAX = 5'h1F;
  localparam int CFG_RW_BIT = 15;
  localparam int CFG_AI_BIT = 14;
  localparam int CFG_GLB_BIT = 13;
  localparam int CFG_RSV_BIT = 12;
  localparam int CFG_ADR_LSB = 8;
  localparam int DIR_RW_BIT = 23;
  localparam int DIR_ADR_LSB = 8;
  localparam int DIR_ADR_MSB = 21;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (4-bit configuration space).
  localparam logic [3:0] REG_PANEL = 4'h1;
  localparam logic [3:0] REG_PLANE_CTL = 4'h2;
  localparam logic [3:0] REG_PLANE_SEL = 4'h3;
  localparam logic [3:0] REG_DRV_PTR = 4'h4;
  localparam logic [3:0] REG_DSP_LO = 4'h9;
  localparam logic [3:0] REG_DSP_HI = 4'hA;

  // Panel configuration fields.
  localparam int PNL_COLOR_BIT = 0;
  localparam int PNL_PI_BIT = 1;
  localparam int PNL_RGEO_BIT = 2;
  localparam int PNL_GGEO_BIT = 3;
  localparam logic [7:0] PANEL_RST = 8'h00;

  // Plane counter control fields.
  localparam int PLC_SLOW_BIT = 7;
  localparam int PLC_AUTO_BIT = 6;
  localparam int PLC_RATE_MSB = 5;
  localparam logic [7:0] PLANE_CTL_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Super-frame enable patterns, bit i is multiplex cycle i.
  localparam logic [11:0] PAT_FULL = 12'hFFF;
  localparam logic [11:0] PAT_TWO_THIRD = 12'hB6D;
  localparam logic [11:0] PAT_HALF = 12'h555;
  localparam logic [11:0] PAT_THIRD = 12'h492;
  localparam logic [11:0] PAT_QUARTER = 12'h222;
  localparam logic [11:0] PAT_OFF = 12'h000;

endpackage : lmhcd_pkg

// >>> dv/lmhcd_host_model.sv
module lmhcd_host_model (
  // Serial pins towards the device.
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  input wire logic dout_i,
  input wire logic dout_oe_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // The serial clock stands low outside frames and readbacks.
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end

  task automatic send(input logic [23:0] w, input int n);
    cs_n_o = 1'b0;
    #20;
    for (int i = n - 1; i >= 0; i--) begin
      din_o = w[i];
      #7.5 sclk_o = 1'b1;
      #7.5;
      if (i > 0) begin
        sclk_o = 1'b0;
      end
    end
    cs_n_o = 1'b1;
    #7.5 sclk_o = 1'b0;
    // Data is meaningless now, so it is flipped rather than left at its last value.
    din_o = ~din_o;
    #150;
  endtask : send

  task automatic read8(output logic [7:0] d, output logic oe);
    logic bus;
    bus = 1'b0;
    oe = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      #7.5 sclk_o = 1'b1;
      // A released line floats, so it is shown as the opposite of its last level.
      bus = dout_oe_i ? dout_i : ~bus;
      d[i] = bus;
      oe = oe & dout_oe_i;
      #7.5 sclk_o = 1'b0;
    end
    #150;
  endtask : read8
endmodule : lmhcd_host_model

// >>> dv/lmhcd_props.sv
module lmhcd_props
  import lmhcd_pkg::*;
#(
  parameter int SEC_CYCLES = SEC_CYCLES_DEF
) (
  // Clock, reset, enable.
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Serial link.
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  // Position and display drive.
  input wire logic [7:0] drv_pos_i,
  input wire logic [7:0] row_o,
  input wire logic [7:0] col_red_o,
  input wire logic [7:0] col_grn_o,
  input wire logic [1:0] plane_o,
  input wire logic plane_step_o
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // A row dwells far longer than eight cycles; eight keeps the unrolling cheap.
  sequence s_row_dwell;
    $stable(row_o) [*8];
  endsequence
  sequence s_cs_high_3;
    cs_n_i && $past(cs_n_i) && $past(cs_n_i, 2) && $past(cs_n_i, 3);
  endsequence

  chk_oe_needs_cs: assert property (dout_oe_o |-> cs_n_i)
    else $error("read drive while select low");
  chk_dout_quiet: assert property (!dout_oe_o |-> !dout_o)
    else $error("serial out not parked low");
  chk_oe_late: assert property ($rose(dout_oe_o) |-> s_cs_high_3)
    else $error("read drive too soon after frame end");
  chk_reset_clears: assert property (disable iff (1'b0)
    sys_rst_i |=> row_o == 8'h00 && plane_o == 2'h0 && !plane_step_o)
    else $error("outputs not cleared by reset");
  chk_step_pulse: assert property (plane_step_o |=> !plane_step_o)
    else $error("plane step longer than one cycle");
  chk_step_moves: assert property (plane_step_o |-> ##[0:1] $changed(plane_o))
    else $error("plane step without plane change");
  chk_row_onehot: assert property ($onehot0(row_o))
    else $error("more than one row active");
  chk_row_dwell: assert property ($changed(row_o) && row_o != 8'h00 |=> s_row_dwell)
    else $error("row changed too early");
  chk_col_in_row: assert property (col_red_o != 8'h00 || col_grn_o != 8'h00 |-> row_o != 8'h00)
    else $error("columns on with no row");
  chk_ce_freeze: assert property (!ce_i |=> $stable(row_o) && $stable(plane_o) && $stable(plane_step_o))
    else $error("state moved while disabled");
endmodule : lmhcd_props

bind lmhcd_decoder lmhcd_props #(.SEC_CYCLES(SEC_CYCLES)) u_lmhcd_props (
  .ref_clk_i(ref_clk_i),
  .sys_rst_i(sys_rst_i),
  .ce_i(ce_i),
  .sclk_i(sclk_i),
  .cs_n_i(cs_n_i),
  .din_i(din_i),
  .dout_o(dout_o),
  .dout_oe_o(dout_oe_o),
  .drv_pos_i(drv_pos_i),
  .row_o(row_o),
  .col_red_o(col_red_o),
  .col_grn_o(col_grn_o),
  .plane_o(plane_o),
  .plane_step_o(plane_step_o)
);

// >>> dv/test_lmhcd_decoder.sv
module test_lmhcd_decoder
  import lmhcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int SEC_SIM = 100;
  localparam logic [7:0] POS = 8'h03;
  logic ref_clk, sys_rst, ce, sclk, cs_n, din, dout, dout_oe, plane_step;
  logic [7:0] drv_pos, row, col_red, col_grn;
  logic [1:0] plane;
  int bad_count = 0;
  int samples_checked = 0;

  lmhcd_decoder #(.SEC_CYCLES(SEC_SIM)) DUT (
    .ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .ce_i(ce), .sclk_i(sclk),
    .cs_n_i(cs_n), .din_i(din), .dout_o(dout), .dout_oe_o(dout_oe),
    .drv_pos_i(drv_pos), .row_o(row), .col_red_o(col_red), .col_grn_o(col_grn),
    .plane_o(plane), .plane_step_o(plane_step)
  );
  lmhcd_host_model host (
    .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout), .dout_oe_i(dout_oe)
  );

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  function automatic logic [23:0] cw(input logic rw, input logic ai, input logic glb,
                                     input logic [3:0] a, input logic [7:0] d);
    return {8'h00, rw, ai, glb, 1'b0, a, d};
  endfunction : cw

  function automatic logic [23:0] dw(input logic rw, input logic [13:0] a, input logic [7:0] d);
    return {rw, 1'b0, a, d};
  endfunction : dw

  task automatic rd_chk(input logic [23:0] w, input int n, input logic eo, input logic [7:0] ed);
    logic [7:0] d;
    logic oe;
    host.send(w, n);
    host.read8(d, oe);
    check({15'h0000, oe}, {15'h0000, eo});
    if (eo) begin
      check({8'h00, d}, {8'h00, ed});
    end
  endtask : rd_chk

  // Mode 0 waits for a plane step, mode 1 for the plane to reach v.
  task automatic wait_for(input int mode, input logic [1:0] v);
    int k;
    k = 0;
    while (((mode == 0) ? plane_step !== 1'b1 : plane !== v) && k < 5000) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 5000) begin
      bad_count++;
      end_sim();
    end
  endtask : wait_for

  // Counts reference cycles from one automatic plane step to the next.
  task automatic step_gap(input int exp);
    int k;
    wait_for(0, 2'h0);
    @(posedge ref_clk);
    k = 1;
    while (plane_step !== 1'b1 && k < 5000) begin
      @(posedge ref_clk);
      k++;
    end
    check(16'(k), 16'(exp));
    if (k >= 5000) begin
      end_sim();
    end
  endtask : step_gap

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_dsp();
    check({14'h0000, plane}, 16'h0000);
    host.send(cw(1'b0, 1'b0, 1'b1, REG_DRV_PTR, POS), 16);
    rd_chk(cw(1'b1, 1'b0, 1'b0, REG_DSP_LO, 8'h00), 16, 1'b1, 8'h00);
    rd_chk(cw(1'b1, 1'b0, 1'b0, REG_DSP_HI, 8'h00), 16, 1'b1, 8'h00);
    host.send(cw(1'b0, 1'b0, 1'b1, REG_DSP_HI, 8'h10), 16);
    host.send(cw(1'b0, 1'b0, 1'b1, REG_DSP_LO, 8'h35), 16);
    rd_chk(cw(1'b1, 1'b0, 1'b0, REG_DSP_HI, 8'h00), 16, 1'b1, 8'h10);
    host.send({16'h0000, 8'hA5}, 8);
    host.send({16'h0000, 8'h3C}, 8);
    rd_chk(dw(1'b1, 14'h1035, 8'h00), 24, 1'b1, 8'hA5);
    rd_chk(dw(1'b1, 14'h1036, 8'h00), 24, 1'b1, 8'h3C);
    rd_chk(cw(1'b1, 1'b0, 1'b0, REG_DSP_LO, 8'h00), 16, 1'b1, 8'h37);
    host.send(dw(1'b0, 14'h2038, 8'h5A), 24);
    rd_chk(dw(1'b1, 14'h2038, 8'h00), 24, 1'b1, 8'h5A);
    rd_chk(dw(1'b1, 14'h2028, 8'h00), 24, 1'b0, 8'h00);
  endtask : t_dsp

  task automatic t_bad();
    int lens [6];
    lens = '{7, 9, 15, 17, 23, 25};
    foreach (lens[i]) begin
      host.send(cw(1'b0, 1'b0, 1'b1, REG_DSP_LO, 8'hEE), lens[i]);
    end
    host.send(cw(1'b0, 1'b0, 1'b1, REG_DSP_LO, 8'hEE) | 24'h001000, 16);
    rd_chk(cw(1'b1, 1'b0, 1'b0, REG_DSP_LO, 8'h00), 16, 1'b1, 8'h37);
    rd_chk(cw(1'b1, 1'b0, 1'b0, 4'hF, 8'h00), 16, 1'b1, 8'h00);
  endtask : t_bad

  task automatic t_drvptr();
    rd_chk(cw(1'b1, 1'b1, 1'b0, REG_DSP_LO, 8'h00), 16, 1'b1, 8'h37);
    rd_chk(cw(1'b1, 1'b0, 1'b0, REG_DSP_LO, 8'h00), 16, 1'b0, 8'h00);
    rd_chk(cw(1'b1, 1'b0, 1'b1, REG_DSP_LO, 8'h00), 16, 1'b0, 8'h00);
    host.send(cw(1'b0, 1'b0, 1'b1, REG_DRV_PTR, 8'h02), 16);
    host.send(cw(1'b0, 1'b1, 1'b0, REG_DSP_LO, 8'h77), 16);
    rd_chk(cw(1'b1, 1'b0, 1'b0, REG_DSP_LO, 8'h00), 16, 1'b1, 8'h37);
    rd_chk(dw(1'b1, 14'h1035, 8'h00), 24, 1'b1, 8'hA5);
  endtask : t_drvptr

  task automatic t_plane();
    logic [1:0] p1;
    host.send(cw(1'b0, 1'b0, 1'b1, REG_PLANE_CTL, 8'h42), 16);
    step_gap(SEC_SIM / 2);
    wait_for(0, 2'h0);
    repeat (2) @(posedge ref_clk);
    p1 = plane;
    ce <= 1'b0;
    repeat (20) @(posedge ref_clk);
    ce <= 1'b1;
    wait_for(0, 2'h0);
    repeat (2) @(posedge ref_clk);
    check({14'h0000, plane}, {14'h0000, p1 + 2'h1});
    host.send(cw(1'b0, 1'b0, 1'b1, REG_PLANE_CTL, 8'hC2), 16);
    step_gap(2 * SEC_SIM);
    host.send(cw(1'b0, 1'b0, 1'b1, REG_PLANE_CTL, 8'h00), 16);
    host.send(cw(1'b0, 1'b0, 1'b1, REG_PLANE_SEL, 8'h02), 16);
    wait_for(1, 2'h2);
    check({14'h0000, plane}, 16'h0002);
  endtask : t_plane

  // Two-bit mono panel: row 0 of plane 0 holds codes 11, 10, 01, 00 in columns 3..0.
  // Counting enabled frames over one super frame does not depend on where it starts.
  task automatic t_gray();
    int cnt_r [4];
    int cnt_g [4];
    int k;
    cnt_r = '{0, 0, 0, 0};
    cnt_g = '{0, 0, 0, 0};
    host.send(cw(1'b0, 1'b0, 1'b1, REG_PLANE_SEL, 8'h00), 16);
    host.send(cw(1'b0, 1'b0, 1'b1, REG_PANEL, 8'h0A), 16);
    host.send(dw(1'b0, 14'h0060, 8'h0C), 24);
    host.send(dw(1'b0, 14'h0061, 8'h0A), 24);
    host.send(dw(1'b0, 14'h0070, 8'h0C), 24);
    host.send(dw(1'b0, 14'h0071, 8'h0A), 24);
    for (int f = 0; f < SF_LEN; f++) begin
      k = 0;
      while (row !== 8'h80 && k < 1000) begin
        @(posedge ref_clk);
        k++;
      end
      while (row !== 8'h01 && k < 1000) begin
        @(posedge ref_clk);
        k++;
      end
      if (k >= 1000) begin
        bad_count++;
        end_sim();
      end
      for (int j = 0; j < 4; j++) begin
        cnt_r[j] += int'(col_red[j]);
        cnt_g[j] += int'(col_grn[j]);
      end
    end
    check(16'(cnt_r[3]), 16'h000C);
    check(16'(cnt_r[2]), 16'h0008);
    check(16'(cnt_r[1]), 16'h0004);
    check(16'(cnt_r[0]), 16'h0000);
    check(16'(cnt_g[2]), 16'h0006);
    check(16'(cnt_g[1]), 16'h0003);
    host.send(dw(1'b0, 14'h2065, 8'hC3), 24);
    rd_chk(dw(1'b1, 14'h2065, 8'h00), 24, 1'b1, 8'hC3);
    rd_chk(dw(1'b1, 14'h0065, 8'h00), 24, 1'b1, 8'h00);
    host.send(cw(1'b0, 1'b0, 1'b1, REG_PANEL, 8'h03), 16);
    host.send(dw(1'b0, 14'h3032, 8'h5C), 24);
    rd_chk(dw(1'b1, 14'h3032, 8'h00), 24, 1'b1, 8'h5C);
    rd_chk(dw(1'b1, 14'h2032, 8'h00), 24, 1'b1, 8'h00);
  endtask : t_gray

  initial begin
    sys_rst <= 1'b1;
    ce <= 1'b1;
    drv_pos <= POS;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    t_dsp();
    t_bad();
    t_drvptr();
    t_plane();
    t_gray();
    end_sim();
  end
endmodule : test_lmhcd_decoder

// >>> logic/lmhcd_decoder.sv
module lmhcd_decoder
  import lmhcd_pkg::*;
#(
  parameter int SEC_CYCLES = SEC_CYCLES_DEF
) (
  // Clock, reset, enable.
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Serial link.
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  // Allocated driver position.
  input wire logic [7:0] drv_pos_i,
  // Display drive.
  output logic [7:0] row_o,
  output logic [7:0] col_red_o,
  output logic [7:0] col_grn_o,
  output logic [1:0] plane_o,
  output logic plane_step_o
);

  typedef enum logic {ST_IDLE, ST_EXEC} lmhcd_state_t;

  typedef struct packed {
    lmhcd_state_t st;
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic rst_lnk;
    logic [23:0] word;
    logic [4:0] nbits;
    logic [13:0] dsp_ptr;
    logic [7:0] drv_ptr;
    logic [7:0] panel;
    logic [7:0] plane_ctl;
    logic [1:0] plane;
    logic [31:0] acc;
    logic [5:0] secs;
    logic step;
    logic [15:0] mux_cnt;
    logic [2:0] row;
    logic [3:0] frame;
    logic [7:0] row_out;
    logic [7:0] red_out;
    logic [7:0] grn_out;
    logic [7:0] rd_byte;
    logic rd_en;
    logic [63:0][7:0] mem;
  } lmhcd_regs_t;

  lmhcd_regs_t s_r;
  lmhcd_regs_t s_nxt;
  logic [23:0] lnk_word;
  logic [4:0] lnk_nbits;

  ////////////////////////////////////////////////////////////////////////////
  // Link side runs on the serial clock; its word and count only change while
  // select is low, so they are quiet when sampled after select rises.
  lmhcd_link_rx u_link (
    .sclk_i(sclk_i),
    .rst_i(s_r.rst_lnk),
    .cs_n_i(cs_n_i),
    .din_i(din_i),
    .dout_o(dout_o),
    .dout_oe_o(dout_oe_o),
    .rd_byte_i(s_r.rd_byte),
    .rd_en_i(s_r.rd_en),
    .word_o(lnk_word),
    .nbits_o(lnk_nbits)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Maps a global 14-bit display address onto this driver: bit 6 is the hit,
  // bits 5:0 the local byte index.
  function automatic logic [6:0] map_addr(input logic [13:0] a, input logic pi,
                                          input logic color, input logic [7:0] pos);
    logic hit;
    logic [5:0] idx;
    hit = 1'b0;
    idx = 6'h00;
    if (!pi && !color) begin
      hit = (a[11:4] == pos);
      idx = {a[13:12], a[3:0]};
    end else if (!pi && color) begin
      hit = (a[10:3] == pos);
      idx = {a[13:12], a[11], a[2:0]};
    end else if (pi && !color) begin
      hit = (a[12:5] == pos);
      idx = {a[13], a[4:0]};
    end else begin
      hit = (a[11:4] == pos);
      idx = {a[13], a[12], a[3:0]};
    end
    map_addr = {hit, idx};
  endfunction : map_addr

  // Enable of one pixel in the current super-frame cycle.
  function automatic logic pixel_on(input logic [1:0] code, input logic geo,
                                    input logic [3:0] frame);
    logic [11:0] pat;
    pat = PAT_OFF;
    case (code)
      2'b11: pat = PAT_FULL;
      2'b10: pat = geo ? PAT_HALF : PAT_TWO_THIRD;
      2'b01: pat = geo ? PAT_QUARTER : PAT_THIRD;
      default: pat = PAT_OFF;
    endcase
    pixel_on = pat[frame];
  endfunction : pixel_on

  function automatic logic [7:0] reg_read(input lmhcd_regs_t s, input logic [3:0] a);
    case (a)
      REG_PANEL: reg_read = s.panel;
      REG_PLANE_CTL: reg_read = s.plane_ctl;
      REG_PLANE_SEL: reg_read = {6'h00, s.plane};
      REG_DRV_PTR: reg_read = s.drv_ptr;
      REG_DSP_LO: reg_read = s.dsp_ptr[7:0];
      REG_DSP_HI: reg_read = {2'h0, s.dsp_ptr[13:8]};
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read

  ////////////////////////////////////////////////////////////////////////////
  logic pi;
  logic color;
  logic [6:0] m8;
  logic [6:0] m24;
  logic cfg_rd;
  logic cfg_glb;
  logic cfg_sel;
  logic [3:0] cfg_adr;
  logic [7:0] dat;
  logic [1:0] last_plane;
  logic [5:0] rate;
  logic [31:0] acc_sum;
  logic [5:0] base;
  logic [7:0] red_hi;
  logic [7:0] red_lo;
  logic [7:0] grn_hi;
  logic [7:0] grn_lo;

  assign pi = s_r.panel[PNL_PI_BIT];
  assign color = s_r.panel[PNL_COLOR_BIT];
  assign m8 = map_addr(s_r.dsp_ptr, pi, color, drv_pos_i);
  assign m24 = map_addr(s_r.word[DIR_ADR_MSB:DIR_ADR_LSB], pi, color, drv_pos_i);
  assign cfg_rd = s_r.word[CFG_RW_BIT];
  assign cfg_glb = s_r.word[CFG_GLB_BIT] & ~cfg_rd;
  assign cfg_sel = cfg_glb | (drv_pos_i == s_r.drv_ptr);
  assign cfg_adr = s_r.word[CFG_ADR_LSB +: 4];
  assign dat = s_r.word[7:0];
  assign last_plane = pi ? 2'h1 : 2'h3;
  assign rate = s_r.plane_ctl[PLC_RATE_MSB:0];
  assign acc_sum = s_r.acc + (s_r.plane_ctl[PLC_SLOW_BIT] ? 32'h1 : {26'h0, rate});

  // Row bytes of the refresh plane; two-bit mode keeps high then low bits.
  always_comb begin
    base = pi ? {s_r.plane[0], 5'h00} : {s_r.plane, 4'h0};
    red_hi = pi ? s_r.mem[base + {2'h0, s_r.row, 1'b0}] : s_r.mem[base + {3'h0, s_r.row}];
    red_lo = s_r.mem[base + {2'h0, s_r.row, 1'b1}];
    grn_hi = pi ? s_r.mem[base + {2'h1, s_r.row, 1'b0}] : s_r.mem[base + {3'h1, s_r.row}];
    grn_lo = s_r.mem[base + {2'h1, s_r.row, 1'b1}];
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    s_nxt.rst_lnk = 1'b0;
    s_nxt.step = 1'b0;
    // The first stage feeds only the second.
    s_nxt.cs_s1 = cs_n_i;
    s_nxt.cs_s2 = s_r.cs_s1;
    s_nxt.cs_s3 = s_r.cs_s2;

    // A new frame ends any pending readback.
    if (!s_r.cs_s2 && s_r.cs_s3) begin
      s_nxt.rd_en = 1'b0;
    end

    case (s_r.st)
      ST_IDLE: begin
        if (s_r.cs_s2 && !s_r.cs_s3) begin
          s_nxt.word = lnk_word;
          s_nxt.nbits = lnk_nbits;
          s_nxt.st = ST_EXEC;
        end
      end
      ST_EXEC: begin
        s_nxt.st = ST_IDLE;
        case (s_r.nbits)
          LEN_DSP: begin
            if (m8[6]) begin
              s_nxt.mem[m8[5:0]] = dat;
            end
            s_nxt.dsp_ptr = s_r.dsp_ptr + 14'h0001;
          end
          LEN_CFG: begin
            // Reserved encodings are left alone rather than guessed at.
            if (!s_r.word[CFG_RSV_BIT]) begin
              if (cfg_sel && cfg_rd) begin
                s_nxt.rd_byte = reg_read(s_r, cfg_adr);
                s_nxt.rd_en = 1'b1;
              end else if (cfg_sel) begin
                case (cfg_adr)
                  REG_PANEL: s_nxt.panel = dat;
                  REG_PLANE_CTL: s_nxt.plane_ctl = dat;
                  REG_PLANE_SEL: s_nxt.plane = dat[1:0] & last_plane;
                  REG_DRV_PTR: s_nxt.drv_ptr = dat;
                  REG_DSP_LO: s_nxt.dsp_ptr[7:0] = dat;
                  REG_DSP_HI: s_nxt.dsp_ptr[13:8] = dat[5:0];
                  default: s_nxt.panel = s_r.panel;
                endcase
              end
              // Every driver keeps its own copy of the pointer in step.
              if (!cfg_glb && s_r.word[CFG_AI_BIT]) begin
                s_nxt.drv_ptr = s_nxt.drv_ptr + 8'h01;
              end
            end
          end
          LEN_DIR: begin
            if (m24[6] && s_r.word[DIR_RW_BIT]) begin
              s_nxt.rd_byte = s_r.mem[m24[5:0]];
              s_nxt.rd_en = 1'b1;
            end else if (m24[6]) begin
              s_nxt.mem[m24[5:0]] = dat;
            end
          end
          default: s_nxt.nbits = s_r.nbits;
        endcase
      end
      default: s_nxt.st = ST_IDLE;
    endcase

    // Automatic plane stepping: fast mode adds the rate per cycle against one
    // second, slow mode counts whole seconds up to the rate.
    if (s_r.plane_ctl[PLC_AUTO_BIT] && rate != 6'h00) begin
      s_nxt.acc = acc_sum;
      if (acc_sum >= 32'(SEC_CYCLES)) begin
        s_nxt.acc = acc_sum - 32'(SEC_CYCLES);
        if (!s_r.plane_ctl[PLC_SLOW_BIT] || s_r.secs + 6'h01 >= rate) begin
          s_nxt.secs = 6'h00;
          s_nxt.step = 1'b1;
          s_nxt.plane = (s_r.plane >= last_plane) ? 2'h0 : s_r.plane + 2'h1;
        end else begin
          s_nxt.secs = s_r.secs + 6'h01;
        end
      end
    end else begin
      s_nxt.acc = 32'h0;
      s_nxt.secs = 6'h00;
    end

    // Row multiplex and super-frame position.
    if (s_r.mux_cnt == 16'(ROW_CYCLES - 1)) begin
      s_nxt.mux_cnt = 16'h0000;
      s_nxt.row = s_r.row + 3'h1;
      if (s_r.row == 3'(ROWS - 1)) begin
        s_nxt.frame = (s_r.frame == 4'(SF_LEN - 1)) ? 4'h0 : s_r.frame + 4'h1;
      end
    end else begin
      s_nxt.mux_cnt = s_r.mux_cnt + 16'h0001;
    end

    s_nxt.row_out = 8'h01 << s_r.row;
    for (int j = 0; j < 8; j++) begin
      if (pi) begin
        s_nxt.red_out[j] = pixel_on({red_hi[j], red_lo[j]},
                                    s_r.panel[PNL_RGEO_BIT], s_r.frame);
        s_nxt.grn_out[j] = pixel_on({grn_hi[j], grn_lo[j]},
                                    s_r.panel[PNL_GGEO_BIT], s_r.frame);
      end else begin
        s_nxt.red_out[j] = red_hi[j];
        s_nxt.grn_out[j] = grn_hi[j];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset wins over the enable; display memory is cleared so the panel
  // starts dark instead of showing random data.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.rst_lnk <= 1'b1;
      s_r.cs_s1 <= 1'b1;
      s_r.cs_s2 <= 1'b1;
      s_r.cs_s3 <= 1'b1;
      s_r.panel <= PANEL_RST;
      s_r.plane_ctl <= PLANE_CTL_RST;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign row_o = s_r.row_out;
  assign col_red_o = s_r.red_out;
  assign col_grn_o = s_r.grn_out;
  assign plane_o = s_r.plane;
  assign plane_step_o = s_r.step;

endmodule : lmhcd_decoder

// >>> logic/lmhcd_link_rx.sv
module lmhcd_link_rx
  import lmhcd_pkg::*;
(
  // Link clock and reset.
  input wire logic sclk_i,
  input wire logic rst_i,
  // Serial pins.
  input wire logic cs_n_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  // Core side.
  input wire logic [7:0] rd_byte_i,
  input wire logic rd_en_i,
  output logic [23:0] word_o,
  output logic [4:0] nbits_o
);

  typedef struct packed {
    logic [23:0] sh;
    logic [4:0] cnt;
    logic epoch;
  } lmhcd_rxp_t;

  typedef struct packed {
    logic [3:0] rcnt;
    logic epoch;
  } lmhcd_rxn_t;

  lmhcd_rxp_t p_r;
  lmhcd_rxp_t p_nxt;
  lmhcd_rxn_t n_r;
  lmhcd_rxn_t n_nxt;
  logic [3:0] bit_idx;

  ////////////////////////////////////////////////////////////////////////////
  // A falling edge with select high marks a frame boundary; the next rising
  // edge with select low then restarts the count, so the clock may stop
  // between frames without losing anything.
  always_comb begin
    p_nxt = p_r;
    if (!cs_n_i) begin
      if (p_r.epoch != n_r.epoch) begin
        p_nxt.sh = {23'h000000, din_i};
        p_nxt.cnt = 5'h01;
        p_nxt.epoch = n_r.epoch;
      end else begin
        p_nxt.sh = {p_r.sh[22:0], din_i};
        if (p_r.cnt != LEN_MAX) begin
          p_nxt.cnt = p_r.cnt + 5'h01;
        end
      end
    end
  end

  always_comb begin
    n_nxt = n_r;
    if (cs_n_i) begin
      n_nxt.epoch = ~p_r.epoch;
      if (n_r.rcnt != 4'h9) begin
        n_nxt.rcnt = n_r.rcnt + 4'h1;
      end
    end else begin
      n_nxt.rcnt = 4'h0;
    end
  end

  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      p_r <= '0;
    end else begin
      p_r <= p_nxt;
    end
  end

  always_ff @(negedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      n_r <= '0;
    end else begin
      n_r <= n_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The first falling edge after select rises puts D7 out; bits
  // D6..D0 follow on the next seven. Select falling ends the readback at once.
  assign bit_idx = 4'h8 - n_r.rcnt;
  assign dout_oe_o = cs_n_i & rd_en_i & (n_r.rcnt != 4'h0) & (n_r.rcnt != 4'h9);
  assign dout_o = dout_oe_o & rd_byte_i[bit_idx[2:0]];
  assign word_o = p_r.sh;
  assign nbits_o = p_r.cnt;

endmodule : lmhcd_link_rx
